// File: include/jdr_defines.svh
`ifndef JDR_DEFINES_SVH
`define JDR_DEFINES_SVH
`define JDR_CHAIN_W 36
`define JDR_WORD_W 32
`define JDR_IR_W 7
`define JDR_IR_CONTROL 7'h09
`define JDR_IR_SEND 7'h10
`define JDR_IR_RECEIVE 7'h02
`define JDR_WORD_LSB 3
`define JDR_WORD_MSB 34
`define JDR_FULL_BIT 0
`define JDR_HOLD_BIT 1
`define JDR_BREAK_BIT 2
`define JDR_FLUSH_BIT 1
`define JDR_LOAD_BIT 2
`define JDR_VALID_BIT 35
`define JDR_DEBUG_CONTROL_STATUS_JTAG_MASK 32'hC000003F
`endif

// File: include/jdr_pkg.sv
`include "jdr_defines.svh"
package jdr_pkg;
   // state of the test clock side
   typedef struct packed {
      logic [`JDR_CHAIN_W-1:0] chain;
      logic got_one;
      logic hold;
      logic brk_tog;
      logic clr_tog;
      logic rx_tog;
      logic up_tog;
      logic [`JDR_WORD_W-1:0] up_word;
      logic [`JDR_WORD_W-1:0] rx_data;
      logic rx_valid;
      logic rx_flush;
      logic rx_load;
      logic [`JDR_WORD_W-1:0] shadow;
      logic rr_s1, rr_s2, full_s1, full_s2;
      logic dt_s1, dt_s2, dt_seen;
   } jdr_link_type;
   // state of the core clock side
   typedef struct packed {
      logic [`JDR_WORD_W-1:0] debug_control_status;
      logic dtog;
      logic [`JDR_WORD_W-1:0] send_buf;
      logic [`JDR_WORD_W-1:0] rbuf;
      logic full, rr, ov, dl, brk, take, core_rst;
      logic pin_s1, pin_s2, hold_s1, hold_s2;
      logic brk_s1, brk_s2, brk_seen, clr_s1, clr_s2, clr_seen;
      logic rx_s1, rx_s2, rx_seen, up_s1, up_s2, up_seen;
   } jdr_core_type;
endpackage

// File: design/jdr_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "jdr_defines.svh"
module jdr_top (
   input wire logic clock_in,                      // core clock
   input wire logic rst_in,                        // async reset, high
   input wire logic tck_in,                        // test clock
   input wire logic [`JDR_IR_W-1:0] ir_in,         // current instruction
   input wire logic capture_in,                    // tap in capture state
   input wire logic shift_in,                      // tap in shift state
   input wire logic update_in,                     // tap in update state
   input wire logic tdi_in,                        // serial data in
   output logic tdo_out,                           // serial data out
   input wire logic reset_pin_in,                  // processor reset pin
   input wire logic send_write_in,                 // handler writes send word
   input wire logic [`JDR_WORD_W-1:0] send_data_in, // send word
   input wire logic receive_read_in,               // handler reads receive word
   input wire logic handshake_write_in,            // handler writes handshake
   input wire logic debug_control_status_write_in,                 // handler writes control
   input wire logic [`JDR_WORD_W-1:0] debug_control_status_data_in, // control word
   input wire logic monitor_mode_in,               // monitor, else halt mode
   input wire logic abort_mode_in,                 // core in abort mode
   input wire logic special_state_in,              // special debug state
   output logic [`JDR_WORD_W-1:0] receive_data_out, // receive buffer
   output logic send_full_out,                     // send full flag
   output logic receive_full_out,                  // receive full flag
   output logic lost_write_out,                    // lost write flag
   output logic download_out,                      // download flag
   output logic [`JDR_WORD_W-1:0] debug_control_status_out,        // control and status
   output logic core_reset_out,                    // core held in reset
   output logic break_take_out                     // enter handler pulse
);

   jdr_pkg::jdr_link_type ln_q, ln_d;
   jdr_pkg::jdr_core_type co_q, co_d;
   logic up_evt, brk_evt, clr_evt, rx_evt, pend;

   // toggle edges, read only from the second sync stage
   assign up_evt = co_q.up_s2 != co_q.up_seen;
   assign brk_evt = co_q.brk_s2 != co_q.brk_seen;
   assign clr_evt = co_q.clr_s2 != co_q.clr_seen;
   assign rx_evt = co_q.rx_s2 != co_q.rx_seen;
   assign pend = monitor_mode_in ? abort_mode_in : special_state_in;

   // test clock side: chain, update holds, toggles
   always_comb begin
      ln_d = ln_q;
      ln_d.rr_s1 = co_q.rr;
      ln_d.rr_s2 = ln_q.rr_s1;
      ln_d.full_s1 = co_q.full;
      ln_d.full_s2 = ln_q.full_s1;
      ln_d.dt_s1 = co_q.dtog;
      ln_d.dt_s2 = ln_q.dt_s1;
      ln_d.dt_seen = ln_q.dt_s2;
      // control word is still after its toggle, safe to copy
      if (ln_q.dt_s2 != ln_q.dt_seen) begin
         ln_d.shadow = co_q.debug_control_status;
      end
      if (capture_in) begin
         ln_d.chain = '0;
         ln_d.got_one = 1'b0;
         case (ir_in)
            `JDR_IR_CONTROL: begin
               ln_d.chain[`JDR_WORD_MSB:`JDR_WORD_LSB] = ln_q.shadow;
               ln_d.chain[`JDR_HOLD_BIT] = 1'b1;
            end
            `JDR_IR_SEND: begin
               // send word and flag
               // handler only rewrites the word while the flag is clear
               ln_d.chain[`JDR_WORD_MSB:`JDR_WORD_LSB] = co_q.send_buf;
               ln_d.chain[`JDR_FULL_BIT] = ln_q.full_s2;
               ln_d.got_one = ln_q.full_s2;
            end
            `JDR_IR_RECEIVE: begin
               ln_d.chain[`JDR_FULL_BIT] = ln_q.rr_s2;
            end
            default: begin
               ln_d.chain = '0;
            end
         endcase
      end else if (shift_in) begin
         ln_d.chain = {tdi_in, ln_q.chain[`JDR_CHAIN_W-1:1]};
         if (ln_q.got_one && ir_in == `JDR_IR_SEND) begin
            ln_d.clr_tog = ~ln_q.clr_tog;
            ln_d.got_one = 1'b0;
         end
      end else if (update_in) begin
         case (ir_in)
            `JDR_IR_CONTROL: begin
               ln_d.hold = ln_q.chain[`JDR_HOLD_BIT];
               if (ln_q.chain[`JDR_BREAK_BIT]) begin
                  ln_d.brk_tog = ~ln_q.brk_tog;
               end
               ln_d.up_word = ln_q.chain[`JDR_WORD_MSB:`JDR_WORD_LSB];
               ln_d.up_tog = ~ln_q.up_tog;
            end
            `JDR_IR_RECEIVE: begin
               ln_d.rx_data = ln_q.chain[`JDR_WORD_MSB:`JDR_WORD_LSB];
               ln_d.rx_valid = ln_q.chain[`JDR_VALID_BIT];
               ln_d.rx_flush = ln_q.chain[`JDR_FLUSH_BIT];
               ln_d.rx_load = ln_q.chain[`JDR_LOAD_BIT];
               ln_d.rx_tog = ~ln_q.rx_tog;
            end
            default: begin
               ln_d.hold = ln_q.hold;
            end
         endcase
      end
   end

   always_ff @(posedge tck_in or posedge rst_in) begin
      if (rst_in) begin
         ln_q <= '0;
      end else begin
         ln_q <= ln_d;
      end
   end

   // core side: flags, buffers, break and reset
   always_comb begin
      co_d = co_q;
      co_d.take = 1'b0;
      co_d.pin_s1 = reset_pin_in;
      co_d.pin_s2 = co_q.pin_s1;
      co_d.hold_s1 = ln_q.hold;
      co_d.hold_s2 = co_q.hold_s1;
      co_d.brk_s1 = ln_q.brk_tog;
      co_d.brk_s2 = co_q.brk_s1;
      co_d.brk_seen = co_q.brk_s2;
      co_d.clr_s1 = ln_q.clr_tog;
      co_d.clr_s2 = co_q.clr_s1;
      co_d.clr_seen = co_q.clr_s2;
      co_d.rx_s1 = ln_q.rx_tog;
      co_d.rx_s2 = co_q.rx_s1;
      co_d.rx_seen = co_q.rx_s2;
      co_d.up_s1 = ln_q.up_tog;
      co_d.up_s2 = co_q.up_s1;
      co_d.up_seen = co_q.up_s2;
      // handler and debugger writes together are undefined; handler wins
      if (debug_control_status_write_in) begin
         co_d.debug_control_status = debug_control_status_data_in;
      end else if (up_evt) begin
         co_d.debug_control_status = (co_q.debug_control_status & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) | (ln_q.up_word & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK);
      end
      if (co_d.debug_control_status != co_q.debug_control_status) begin
         co_d.dtog = ~co_q.dtog;
      end
      // send flag: set wins over the consume
      if (clr_evt) begin
         co_d.full = 1'b0;
      end
      if (send_write_in) begin
         co_d.full = 1'b1;
         co_d.send_buf = send_data_in;
      end
      if (receive_read_in) begin
         co_d.rr = 1'b0;
      end
      if (handshake_write_in) begin
         co_d.ov = 1'b0;
      end
      if (rx_evt) begin
         co_d.dl = ln_q.rx_load;
         // flush first, so flush with valid still writes
         if (ln_q.rx_flush) begin
            co_d.rr = 1'b0;
         end
         if (ln_q.rx_valid) begin
            if (co_d.rr) begin
               co_d.ov = 1'b1;
            end else begin
               co_d.rbuf = ln_q.rx_data;
               co_d.rr = 1'b1;
            end
         end
      end
      if (co_q.brk && !pend) begin
         co_d.take = 1'b1;
         co_d.brk = 1'b0;
      end
      if (brk_evt) begin
         co_d.brk = 1'b1;
      end
      co_d.core_rst = co_q.pin_s2 | co_q.hold_s2;
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         co_q <= '0;
         co_q.core_rst <= 1'b1;
      end else begin
         co_q <= co_d;
      end
   end

   // outputs straight from flops
   assign tdo_out = ln_q.chain[0];
   assign receive_data_out = co_q.rbuf;
   assign send_full_out = co_q.full;
   assign receive_full_out = co_q.rr;
   assign lost_write_out = co_q.ov;
   assign download_out = co_q.dl;
   assign debug_control_status_out = co_q.debug_control_status;
   assign core_reset_out = co_q.core_rst;
   assign break_take_out = co_q.take;

   // core side checks
   rx_write_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rx_evt && ln_q.rx_valid && (ln_q.rx_flush || !co_q.rr) && !receive_read_in
      |=> co_q.rbuf == $past(ln_q.rx_data) && co_q.rr)
      else $error("receive write lost");
   overflow_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rx_evt && ln_q.rx_valid && !ln_q.rx_flush && co_q.rr && !receive_read_in
      |=> co_q.ov && $stable(co_q.rbuf))
      else $error("overflow not flagged");
   flush_clr_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rx_evt && ln_q.rx_flush && !ln_q.rx_valid |=> !co_q.rr)
      else $error("flush did not clear");
   dl_copy_a: assert property (@(posedge clock_in) disable iff (rst_in)
      rx_evt |=> co_q.dl == $past(ln_q.rx_load))
      else $error("download not copied");
   send_set_a: assert property (@(posedge clock_in) disable iff (rst_in)
      send_write_in |=> send_full_out && send_full_out == 1'b1 && co_q.send_buf == $past(send_data_in))
      else $error("send write not taken");
   read_clr_a: assert property (@(posedge clock_in) disable iff (rst_in)
      receive_read_in && !rx_evt |=> !receive_full_out)
      else $error("read did not clear");
   ov_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
      lost_write_out && !handshake_write_in |=> lost_write_out)
      else $error("lost write dropped");
   break_take_a: assert property (@(posedge clock_in) disable iff (rst_in)
      co_q.brk && !pend && !brk_evt |=> break_take_out && !co_q.brk ##1 !break_take_out)
      else $error("break not taken");
   break_pend_a: assert property (@(posedge clock_in) disable iff (rst_in)
      co_q.brk && pend |=> co_q.brk && !break_take_out)
      else $error("pended break lost");
   hold_rst_a: assert property (@(posedge clock_in) disable iff (rst_in)
      co_q.hold_s2 |=> core_reset_out)
      else $error("hold did not keep reset");
   // reset, flag set and consume, and control update checks
   pin_rst_a: assert property (@(posedge clock_in) disable iff (rst_in)
      co_q.pin_s2 |=> core_reset_out)
      else $error("pin did not keep reset");
   rst_release_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !co_q.pin_s2 && !co_q.hold_s2 |=> !core_reset_out)
      else $error("reset not released");
   send_consume_a: assert property (@(posedge clock_in) disable iff (rst_in)
      clr_evt && !send_write_in |=> !send_full_out)
      else $error("send flag not consumed");
   brk_set_a: assert property (@(posedge clock_in) disable iff (rst_in)
      brk_evt |=> co_q.brk)
      else $error("break request lost");
   debug_control_status_upd_a: assert property (@(posedge clock_in) disable iff (rst_in)
      up_evt && !debug_control_status_write_in
      |=> (debug_control_status_out & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) == ($past(ln_q.up_word) & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK)
         && (debug_control_status_out & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) == ($past(debug_control_status_out) & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK))
      else $error("control update wrong");
   ov_source_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !lost_write_out && !rx_evt |=> !lost_write_out)
      else $error("lost write set without update");
   rr_source_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !receive_full_out && !rx_evt |=> !receive_full_out)
      else $error("receive flag set without write");
   // link side checks
   cap_hold_a: assert property (@(posedge tck_in) disable iff (rst_in)
      capture_in && ir_in == `JDR_IR_CONTROL
      |=> ln_q.chain[`JDR_HOLD_BIT] && !ln_q.chain[`JDR_BREAK_BIT])
      else $error("capture hold bit wrong");
   tx_clear_a: assert property (@(posedge tck_in) disable iff (rst_in)
      shift_in && !capture_in && ln_q.got_one && ir_in == `JDR_IR_SEND
      |=> ln_q.clr_tog != $past(ln_q.clr_tog))
      else $error("send consume missing");

   // capture, shift and update per chain
   ctl_cap_a: assert property (@(posedge tck_in) disable iff (rst_in)
      capture_in && ir_in == `JDR_IR_CONTROL
      |=> ln_q.chain[`JDR_WORD_MSB:`JDR_WORD_LSB] == $past(ln_q.shadow))
      else $error("control capture wrong");
   send_cap_a: assert property (@(posedge tck_in) disable iff (rst_in)
      capture_in && ir_in == `JDR_IR_SEND
      |=> ln_q.chain[`JDR_WORD_MSB:`JDR_WORD_LSB] == $past(co_q.send_buf)
         && ln_q.chain[`JDR_FULL_BIT] == $past(ln_q.full_s2))
      else $error("send capture wrong");
   rx_cap_a: assert property (@(posedge tck_in) disable iff (rst_in)
      capture_in && ir_in == `JDR_IR_RECEIVE |=> tdo_out == $past(ln_q.rr_s2))
      else $error("receive capture wrong");
   chain_shift_a: assert property (@(posedge tck_in) disable iff (rst_in)
      shift_in && !capture_in
      |=> ln_q.chain[`JDR_CHAIN_W-2:0] == $past(ln_q.chain[`JDR_CHAIN_W-1:1])
         && ln_q.chain[`JDR_CHAIN_W-1] == $past(tdi_in))
      else $error("chain shift wrong");
   hold_upd_a: assert property (@(posedge tck_in) disable iff (rst_in)
      update_in && !capture_in && !shift_in && ir_in == `JDR_IR_CONTROL
      |=> ln_q.hold == $past(ln_q.chain[`JDR_HOLD_BIT]))
      else $error("hold not updated");
   hold_keep_a: assert property (@(posedge tck_in) disable iff (rst_in)
      !(update_in && !capture_in && !shift_in && ir_in == `JDR_IR_CONTROL) |=> $stable(ln_q.hold))
      else $error("hold changed without update");
   brk_tog_a: assert property (@(posedge tck_in) disable iff (rst_in)
      update_in && !capture_in && !shift_in && ir_in == `JDR_IR_CONTROL && ln_q.chain[`JDR_BREAK_BIT]
      |=> ln_q.brk_tog != $past(ln_q.brk_tog))
      else $error("break request not sent");
   tx_upd_a: assert property (@(posedge tck_in) disable iff (rst_in)
      update_in && !capture_in && !shift_in && ir_in == `JDR_IR_SEND
      |=> $stable(ln_q.hold) && $stable(ln_q.brk_tog) && $stable(ln_q.up_tog) && $stable(ln_q.rx_tog))
      else $error("send update had effect");
   rx_upd_a: assert property (@(posedge tck_in) disable iff (rst_in)
      update_in && !capture_in && !shift_in && ir_in == `JDR_IR_RECEIVE
      |=> ln_q.rx_tog != $past(ln_q.rx_tog) && ln_q.rx_valid == $past(ln_q.chain[`JDR_VALID_BIT])
         && ln_q.rx_flush == $past(ln_q.chain[`JDR_FLUSH_BIT]))
      else $error("receive update wrong");
   // main scenario covers
   rx_write_c: cover property (@(posedge clock_in) rx_evt && ln_q.rx_valid && !co_q.rr);
   overflow_c: cover property (@(posedge clock_in) rx_evt && ln_q.rx_valid && co_q.rr);
   break_c: cover property (@(posedge clock_in) break_take_out);
   consume_c: cover property (@(posedge clock_in) clr_evt && co_q.full);
   hold_c: cover property (@(posedge clock_in) co_q.hold_s2 && !co_q.pin_s2);

endmodule
`default_nettype wire

// File: bench/jdr_debugger.sv
`timescale 1ns/1ns
`default_nettype none
`include "jdr_defines.svh"
module jdr_debugger (
   output logic tck_out,                  // test clock, still between frames
   output logic [`JDR_IR_W-1:0] ir_out,   // loaded instruction
   output logic capture_out,              // tap in capture
   output logic shift_out,                // tap in shift
   output logic update_out,               // tap in update
   output logic tdi_out,                  // serial data to device
   input wire logic tdo_in                // serial data from device
);
   // everything quiet until the first frame
   initial begin
      {tck_out, ir_out, capture_out, shift_out, update_out, tdi_out} = '0;
   end
   // one 160 ns period; inputs move after the falling edge
   task automatic tick();
      #80 tck_out = 1'b1;
      #80 tck_out = 1'b0;
   endtask
   task automatic idle(input int n);
      repeat (n) tick();
   endtask
   // leading idle lets core flags reach the shadow copies
   task automatic scan(input logic [`JDR_IR_W-1:0] ir, input int n, input logic [35:0] din,
                       output logic [35:0] dout);
      dout = '0;
      ir_out = ir;
      idle(4);
      capture_out = 1'b1;
      tick();
      capture_out = 0;
      for (int i = 0; i < n; i++) begin
         shift_out = 1'b1;
         tdi_out = din[i];
         dout[i] = tdo_in;
         tick();
      end
      shift_out = 0;
      tdi_out = ~tdi_out; // stale bit never lingers
      update_out = 1'b1;
      tick();
      update_out = 0;
   endtask
endmodule
`default_nettype wire

// File: bench/jtag_debug_data_registers_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "jdr_defines.svh"
module jtag_debug_data_registers_tb_top;
   logic clock_in, rst_in, tck, cap, sh, up, tdi, tdo, pin;
   logic [`JDR_IR_W-1:0] ir;
   logic sw, rd, hw, dw, mon, abt, special_debug_state, sfull, rfull, lost, dl, crst, brk, ld;
   logic [31:0] sd, dd, rdata, debug_control_status, w, v;
   logic [35:0] o;
   int errors, n_checks, n_brk;
   initial begin
      clock_in = 0;
      forever #5 clock_in = ~clock_in;
   end
   // counts handler entry pulses
   always @(posedge clock_in) begin
      if (brk === 1'b1) n_brk <= n_brk + 1;
   end
   jdr_top jdr_top_i (.clock_in(clock_in), .rst_in(rst_in), .tck_in(tck), .ir_in(ir),
      .capture_in(cap), .shift_in(sh), .update_in(up), .tdi_in(tdi), .tdo_out(tdo),
      .reset_pin_in(pin), .send_write_in(sw), .send_data_in(sd), .receive_read_in(rd),
      .handshake_write_in(hw), .debug_control_status_write_in(dw), .debug_control_status_data_in(dd), .monitor_mode_in(mon),
      .abort_mode_in(abt), .special_state_in(special_debug_state), .receive_data_out(rdata),
      .send_full_out(sfull), .receive_full_out(rfull), .lost_write_out(lost),
      .download_out(dl), .debug_control_status_out(debug_control_status), .core_reset_out(crst), .break_take_out(brk));
   jdr_debugger jdr_debugger_i (.tck_out(tck), .ir_out(ir), .capture_out(cap), .shift_out(sh),
      .update_out(up), .tdi_out(tdi), .tdo_in(tdo));
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // handler strobes {control, handshake, read, send}, one cycle wide
   task automatic hnd(input logic [3:0] k, input logic [31:0] d);
      @(posedge clock_in);
      {dw, hw, rd, sw} <= k;
      sd <= d;
      dd <= d;
      @(posedge clock_in);
      {dw, hw, rd, sw} <= 4'h0;
      repeat (2) @(posedge clock_in);
      #1;
   endtask
   // receive layout: valid 35, word 34:3, fast load 2, clear 1
   function automatic logic [35:0] frm(input logic b35, input logic [31:0] d, input logic b2, b1);
      return {b35, d, b2, b1, 1'b0};
   endfunction
   // one frame, then time for the core side to see it
   task automatic jscan(input logic [`JDR_IR_W-1:0] c, input int n, input logic [35:0] din);
      jdr_debugger_i.scan(c, n, din, o);
      repeat (8) @(posedge clock_in);
      #1;
   endtask
   initial begin
      {rst_in, pin} = 2'b01;
      {sw, rd, hw, dw, mon, abt, special_debug_state} = '0;
      sd = '0;
      dd = '0;
      void'($urandom(32'hDF3E09B2));
      // a clean rising edge, so the stopped test clock side resets too
      #1 rst_in = 1'b1;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      #1;
      chk("flags", 0, {sfull, rfull, lost, dl});
      w = $urandom;
      hnd(4'h8, w);
      jscan(`JDR_IR_CONTROL, 0, '0);
      @(posedge clock_in);
      pin <= 1'b0;
      repeat (8) @(posedge clock_in);
      #1;
      chk("hold", 1, crst);
      chk("debug_control_status kept", w, debug_control_status);
      v = $urandom;
      jscan(`JDR_IR_CONTROL, 36, frm(1'b0, v, 0, 0));
      chk("capture debug_control_status", w, o[34:3]);
      chk("hold bit", 1, o[1]);
      chk("debug_control_status", (w & ~`JDR_DEBUG_CONTROL_STATUS_JTAG_MASK) | (v & `JDR_DEBUG_CONTROL_STATUS_JTAG_MASK), debug_control_status);
      chk("released", 0, crst);
      $display("test control done");
      // halt mode pended by special state, monitor mode by abort
      for (int m = 0; m < 2; m++) begin
         @(posedge clock_in);
         {mon, abt, special_debug_state} <= m ? 3'b110 : 3'b001;
         #1 n_brk = 0;
         jscan(`JDR_IR_CONTROL, 36, frm(1'b0, debug_control_status, 1, 0));
         chk("pended", 0, n_brk);
         @(posedge clock_in);
         {abt, special_debug_state} <= 2'b00;
         for (int i = 0; i < 50 && n_brk == 0; i++) @(posedge clock_in);
         if (n_brk == 0) begin
            errors++;
            wrap_up();
         end
         repeat (10) @(posedge clock_in);
         #1;
         chk("break once", 1, n_brk);
      end
      $display("test break done");
      w = $urandom;
      hnd(4'h1, w);
      chk("send full", 1, sfull);
      jscan(`JDR_IR_SEND, 36, {$urandom, 4'hF});
      chk("send word", w, o[34:3]);
      chk("send flag", 1, o[0]);
      chk("consumed", 0, sfull);
      jscan(`JDR_IR_SEND, 36, '1);
      chk("no resend", 0, o[0]);
      chk("send kept", w, o[34:3]);
      jscan(7'h7F, 36, '1);
      chk("other code", 0, o);
      chk("tx no effect", 0, {crst, rfull, lost});
      $display("test send done");
      for (int i = 0; i < 4; i++) begin
         w = $urandom;
         ld = 1'($urandom);
         jscan(`JDR_IR_RECEIVE, 36, frm(1'b1, w, ld, 0));
         chk("rx empty", 0, o[0]);
         chk("rx data", w, rdata);
         chk("rx full", 1, rfull);
         chk("download", ld, dl);
         jscan(`JDR_IR_RECEIVE, 36, frm(1'b1, ~w, ~ld, 0));
         chk("rx busy", 1, o[0]);
         chk("lost", 1, lost);
         chk("rx kept", w, rdata);
         chk("download", !ld, dl);
         hnd(4'h4, '0);
         chk("lost clear", 0, lost);
         if (i[0]) begin
            hnd(4'h2, '0);
            chk("read clears", 0, rfull);
         end else begin
            jscan(`JDR_IR_RECEIVE, 36, frm(1'b0, $urandom, ld, 1));
            chk("flushed", 0, rfull);
            chk("no write", w, rdata);
         end
      end
      $display("test receive done");
      wrap_up();
   end
endmodule
`default_nettype wire
